/* File: core/dsci_map.vh */
`ifndef DSCI_MAP_VH
`define DSCI_MAP_VH

// ------------------------------------------------------------
// Register byte offsets
// ------------------------------------------------------------
`define DSCI_ADR_CTRL     8'h00
`define DSCI_ADR_STATUS   8'h04
`define DSCI_ADR_MODE     8'h08
`define DSCI_ADR_EXT      8'h0c
`define DSCI_ADR_ERR      8'h10

// ------------------------------------------------------------
// Control and status fields
// ------------------------------------------------------------
`define DSCI_CTRL_EN      0
`define DSCI_CTRL_RST     1'h1
`define DSCI_ST_BANK_LSB  0
`define DSCI_ST_BANK_MSB  3
`define DSCI_ST_DLL       4
`define DSCI_ST_SREF      5
`define DSCI_ST_RD        6
`define DSCI_ST_WR        7
`define DSCI_ST_INIT_LSB  8
`define DSCI_ST_INIT_MSB  16

// ------------------------------------------------------------
// Error flags
// ------------------------------------------------------------
`define DSCI_ERR_MRS_OPEN 0
`define DSCI_ERR_MRS_GAP  1
`define DSCI_ERR_DLL_CMD  2
`define DSCI_ERR_DLL_RD   3
`define DSCI_ERR_CLOSED   4
`define DSCI_ERR_RSVD     5
`define DSCI_ERR_ACT_OPEN 6
`define DSCI_ERR_W        7

// ------------------------------------------------------------
// Mode register fields and codes
// ------------------------------------------------------------
`define DSCI_MR_BL_LSB    0
`define DSCI_MR_BL_MSB    2
`define DSCI_MR_BT        3
`define DSCI_MR_CL_LSB    4
`define DSCI_MR_CL_MSB    6
`define DSCI_MR_TM        7
`define DSCI_MR_DLLR      8
`define DSCI_AP           8
`define DSCI_EMR_DLL_DIS  0
`define DSCI_EMR_DS0      1
`define DSCI_EMR_DS1      6
`define DSCI_BL_2         3'h1
`define DSCI_BL_4         3'h2
`define DSCI_BL_8         3'h3
`define DSCI_CL_2         3'h2
`define DSCI_CL_25        3'h6
`define DSCI_CL_3         3'h3
`define DSCI_HALF_CL_2    3'h4
`define DSCI_HALF_CL_25   3'h5
`define DSCI_HALF_CL_3    3'h6
`define DSCI_WR_HALF      3'h2

// ------------------------------------------------------------
// Timing counts in link clock cycles
// ------------------------------------------------------------
`define DSCI_DLL_CYCLES   8'hc8
`define DSCI_MRS_GAP      2'h2

`endif

/* File: core/dsci_sync.v */
`timescale 1ns/1ps

module dsci_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk,
  input  wire             rst_n,
  input  wire [WIDTH-1:0] d,
  output wire [WIDTH-1:0] q
);

  reg [WIDTH-1:0] meta;
  reg [WIDTH-1:0] stage;

  always @(posedge clk)
  begin
    if (!rst_n)
    begin
      meta  <= {WIDTH{1'b0}};
      stage <= {WIDTH{1'b0}};
    end
    else
    begin
      meta  <= d;
      stage <= meta;
    end
  end

  assign q = stage;

endmodule // dsci_sync

/* File: core/dsci_burst.v */
`timescale 1ns/1ps

module dsci_burst (
  input  wire [2:0] start_col,
  input  wire [2:0] beat,
  input  wire [2:0] wrap_mask,
  input  wire       interleave,
  output reg  [2:0] col
);

  reg [2:0] step;

  always @*
  begin
    step = 3'h0;
    if (interleave)
      step = start_col ^ beat;
    else
      step = start_col + beat;
    col = (step & wrap_mask) | (start_col & ~wrap_mask);
  end

endmodule // dsci_burst

/* File: core/dsci_core.v */
// Local design decisions: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
`include "dsci_map.vh"

module dsci_core #(
  parameter COLW = 5
) (
  // System
  input  wire        SYS_CLK,
  input  wire        RST_N,
  // Wishbone slave
  input  wire        WB_CYC_I,
  input  wire        WB_STB_I,
  input  wire        WB_WE_I,
  input  wire [7:0]  WB_ADR_I,
  input  wire [3:0]  WB_SEL_I,
  input  wire [31:0] WB_DAT_I,
  output reg  [31:0] WB_DAT_O,
  output reg         WB_ACK_O,
  // Memory command pins
  input  wire        CK,
  input  wire        CKE,
  input  wire        CS_N,
  input  wire        RAS_N,
  input  wire        CAS_N,
  input  wire        WE_N,
  input  wire [1:0]  BA,
  input  wire [11:0] A,
  input  wire [3:0]  DM,
  // Memory data pins
  input  wire [31:0] DQ_IN,
  output reg  [31:0] DQ_OUT,
  output reg         DQ_OE,
  output reg         DQS_OUT,
  output reg         DQS_OE
);

  // ------------------------------------------------------------
  // States of the power-up sequence
  // ------------------------------------------------------------
  localparam ST_PWRUP = 9'h001;
  localparam ST_PALL1 = 9'h002;
  localparam ST_EMRS  = 9'h004;
  localparam ST_MRS1  = 9'h008;
  localparam ST_PALL2 = 9'h010;
  localparam ST_REF1  = 9'h020;
  localparam ST_REF2  = 9'h040;
  localparam ST_MRS2  = 9'h080;
  localparam ST_READY = 9'h100;
  localparam DEPTH    = 4 << COLW;

  function [3:0] bl_beats;
    input [2:0] code;
    begin
      case (code)
        `DSCI_BL_2: bl_beats = 4'h2;
        `DSCI_BL_4: bl_beats = 4'h4;
        `DSCI_BL_8: bl_beats = 4'h8;
        default:    bl_beats = 4'h0;
      endcase
    end
  endfunction

  function [2:0] wrap_of;
    input [3:0] beats;
    reg   [3:0] m;
    begin
      m       = beats - 4'h1;
      wrap_of = m[2:0];
    end
  endfunction

  // ------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ------------------------------------------------------------
  wire [55:0] pins_s;
  wire        ck_s;
  wire        cke_s;
  wire        cs_n_s;
  wire        ras_n_s;
  wire        cas_n_s;
  wire        we_n_s;
  wire [1:0]  ba_s;
  wire [11:0] a_s;
  wire [3:0]  dm_s;
  wire [31:0] dq_s;
  reg         ck_d;
  reg         cke_q;

  dsci_sync #(.WIDTH(56)) u_sync (
    .clk   (SYS_CLK),
    .rst_n (RST_N),
    .d     ({CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, A, DM, DQ_IN}),
    .q     (pins_s)
  );

  assign {ck_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, ba_s, a_s, dm_s, dq_s} = pins_s;

  reg         ctrl_en;
  reg  [11:0] mode_reg;
  reg  [13:0] ext_reg;
  reg  [3:0]  banks_open;
  reg  [8:0]  init_st;
  reg  [8:0]  next_init_st;
  reg  [7:0]  dll_cnt;
  reg         dll_on;
  reg         dll_rst_wait;
  reg         in_sr;
  reg  [1:0]  gap;
  reg  [6:0]  err;

  wire ck_rise = ck_s & ~ck_d;
  wire ck_fall = ~ck_s & ck_d;
  wire ck_edge = ck_rise | ck_fall;
  wire sel     = ck_rise & cke_q & ~cs_n_s & ctrl_en;
  wire cmd_mrs  = sel & ~ras_n_s & ~cas_n_s & ~we_n_s & (ba_s == 2'b00);
  wire cmd_emrs = sel & ~ras_n_s & ~cas_n_s & ~we_n_s & (ba_s == 2'b01);
  wire cmd_ref  = sel & cke_s & ~ras_n_s & ~cas_n_s & we_n_s;
  wire sr_entry = sel & ~cke_s & ~ras_n_s & ~cas_n_s & we_n_s;
  wire cmd_act  = sel & ~ras_n_s & cas_n_s & we_n_s;
  wire cmd_rd   = sel & ras_n_s & ~cas_n_s & we_n_s;
  wire cmd_wr   = sel & ras_n_s & ~cas_n_s & ~we_n_s;
  wire cmd_bst  = sel & ras_n_s & cas_n_s & ~we_n_s;
  wire cmd_pre  = sel & ~ras_n_s & cas_n_s & ~we_n_s;
  wire cmd_exec = sel & ~(ras_n_s & cas_n_s & we_n_s);
  wire bank_hit = banks_open[ba_s];

  // ------------------------------------------------------------
  // Mode decode
  // ------------------------------------------------------------
  wire [3:0] beats = bl_beats(mode_reg[`DSCI_MR_BL_MSB:`DSCI_MR_BL_LSB]);
  wire [2:0] wmask = wrap_of(beats);
  wire       ilv   = mode_reg[`DSCI_MR_BT];
  reg  [2:0] cl_half;
  reg        cl_bad;

  always @*
  begin
    cl_half = `DSCI_HALF_CL_2;
    cl_bad  = 1'b0;
    case (mode_reg[`DSCI_MR_CL_MSB:`DSCI_MR_CL_LSB])
      `DSCI_CL_2:  cl_half = `DSCI_HALF_CL_2;
      `DSCI_CL_25: cl_half = `DSCI_HALF_CL_25;
      `DSCI_CL_3:  cl_half = `DSCI_HALF_CL_3;
      default:     cl_bad  = 1'b1;
    endcase
  end

  // ------------------------------------------------------------
  // Burst engines
  // ------------------------------------------------------------
  reg  [31:0]     mem [0:DEPTH-1];
  reg             rd_act;
  reg  [2:0]      rd_wait;
  reg  [3:0]      rd_beat;
  reg  [1:0]      rd_bank;
  reg  [COLW-1:0] rd_start;
  reg             wr_act;
  reg  [2:0]      wr_wait;
  reg  [3:0]      wr_beat;
  reg  [1:0]      wr_bank;
  reg  [COLW-1:0] wr_start;
  wire [2:0]      rd_col;
  wire [2:0]      wr_col;

  dsci_burst u_rd_burst (
    .start_col  (rd_start[2:0]),
    .beat       (rd_beat[2:0]),
    .wrap_mask  (wmask),
    .interleave (ilv),
    .col        (rd_col)
  );

  dsci_burst u_wr_burst (
    .start_col  (wr_start[2:0]),
    .beat       (wr_beat[2:0]),
    .wrap_mask  (wmask),
    .interleave (ilv),
    .col        (wr_col)
  );

  wire [COLW+1:0] rd_idx  = {rd_bank, rd_start[COLW-1:3], rd_col};
  wire [COLW+1:0] wr_idx  = {wr_bank, wr_start[COLW-1:3], wr_col};
  wire            rd_out  = ck_edge & rd_act & (rd_wait == 3'h1);
  wire            wr_take = ck_edge & wr_act & (wr_wait == 3'h1) & ~cmd_rd;
  integer         i;

  always @(posedge SYS_CLK)
  begin
    if (wr_take)
    begin
      for (i = 0; i < 4; i = i + 1)
      begin
        if (!dm_s[i])
          mem[wr_idx][8*i +: 8] <= dq_s[8*i +: 8];
      end
    end
  end

  // ------------------------------------------------------------
  // Error flags raised by the command stream
  // ------------------------------------------------------------
  wire [6:0] err_set;
  assign err_set[`DSCI_ERR_MRS_OPEN] = (cmd_mrs | cmd_emrs) & (|banks_open);
  assign err_set[`DSCI_ERR_MRS_GAP]  = cmd_exec & (gap > 2'h1);
  assign err_set[`DSCI_ERR_DLL_CMD]  = cmd_exec & dll_rst_wait;
  assign err_set[`DSCI_ERR_DLL_RD]   = cmd_rd & ((dll_cnt != 8'h00) | ~dll_on);
  assign err_set[`DSCI_ERR_CLOSED]   = (cmd_rd | cmd_wr) & ~bank_hit;
  assign err_set[`DSCI_ERR_RSVD]     = cmd_rd & (cl_bad | (beats == 4'h0));
  assign err_set[`DSCI_ERR_ACT_OPEN] = cmd_act & bank_hit;

  wire wb_req   = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire wb_write = wb_req & WB_WE_I & WB_SEL_I[0];
  wire [6:0] err_clr = (wb_write && WB_ADR_I == `DSCI_ADR_ERR) ? WB_DAT_I[6:0] : 7'h00;

  // ------------------------------------------------------------
  // Power-up sequence tracking
  // ------------------------------------------------------------
  always @*
  begin
    next_init_st = init_st;
    case (init_st)
      ST_PWRUP: if (cke_s) next_init_st = ST_PALL1;
      ST_PALL1: if (cmd_pre & a_s[`DSCI_AP]) next_init_st = ST_EMRS;
      ST_EMRS:  if (cmd_emrs) next_init_st = ST_MRS1;
      ST_MRS1:  if (cmd_mrs & a_s[`DSCI_MR_DLLR]) next_init_st = ST_PALL2;
      ST_PALL2: if (cmd_pre & a_s[`DSCI_AP]) next_init_st = ST_REF1;
      ST_REF1:  if (cmd_ref) next_init_st = ST_REF2;
      ST_REF2:  if (cmd_ref) next_init_st = ST_MRS2;
      ST_MRS2:  if (cmd_mrs & ~a_s[`DSCI_MR_DLLR]) next_init_st = ST_READY;
      ST_READY: next_init_st = ST_READY;
      default:  next_init_st = ST_PWRUP;
    endcase
  end

  // ------------------------------------------------------------
  // Command state
  // ------------------------------------------------------------
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      ck_d         <= 1'b0;
      cke_q        <= 1'b0;
      init_st      <= ST_PWRUP;
      mode_reg     <= 12'h000;
      ext_reg      <= 14'h0000;
      banks_open   <= 4'h0;
      dll_cnt      <= 8'h00;
      dll_on       <= 1'b0;
      dll_rst_wait <= 1'b0;
      in_sr        <= 1'b0;
      gap          <= 2'h0;
      err          <= 7'h00;
    end
    else
    begin
      ck_d    <= ck_s;
      init_st <= next_init_st;
      err     <= (err & ~err_clr) | err_set;
      if (ck_rise)
      begin
        cke_q <= cke_s;
        if (gap != 2'h0)
          gap <= gap - 2'h1;
        if (dll_cnt != 8'h00)
          dll_cnt <= dll_cnt - 8'h01;
        if (dll_cnt <= 8'h01)
          dll_rst_wait <= 1'b0;
      end
      if (cmd_mrs)
      begin
        mode_reg <= a_s;
        gap      <= `DSCI_MRS_GAP;
        if (a_s[`DSCI_MR_DLLR])
        begin
          dll_cnt      <= `DSCI_DLL_CYCLES;
          dll_rst_wait <= 1'b1;
        end
      end
      if (cmd_emrs)
      begin
        ext_reg <= {ba_s, a_s};
        gap     <= `DSCI_MRS_GAP;
        dll_on  <= ~a_s[`DSCI_EMR_DLL_DIS];
        if (!a_s[`DSCI_EMR_DLL_DIS])
          dll_cnt <= `DSCI_DLL_CYCLES;
      end
      if (sr_entry)
        in_sr <= 1'b1;
      if (ck_rise & in_sr & cke_s)
      begin
        in_sr   <= 1'b0;
        dll_on  <= 1'b1;
        dll_cnt <= `DSCI_DLL_CYCLES;
      end
      if (cmd_act)
        banks_open[ba_s] <= 1'b1;
      if (cmd_pre)
      begin
        if (a_s[`DSCI_AP])
          banks_open <= 4'h0;
        else
          banks_open[ba_s] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Read and write bursts
  // ------------------------------------------------------------
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      rd_act   <= 1'b0;
      rd_wait  <= 3'h0;
      rd_beat  <= 4'h0;
      rd_bank  <= 2'h0;
      rd_start <= {COLW{1'b0}};
      wr_act   <= 1'b0;
      wr_wait  <= 3'h0;
      wr_beat  <= 4'h0;
      wr_bank  <= 2'h0;
      wr_start <= {COLW{1'b0}};
      DQ_OUT   <= 32'h0000_0000;
      DQ_OE    <= 1'b0;
      DQS_OUT  <= 1'b0;
      DQS_OE   <= 1'b0;
    end
    else
    begin
      if (rd_out)
      begin
        DQ_OUT  <= mem[rd_idx];
        DQS_OUT <= ck_rise;
        DQ_OE   <= cke_s;
        DQS_OE  <= cke_s;
        rd_beat <= rd_beat + 4'h1;
        if (rd_beat == beats - 4'h1)
          rd_act <= 1'b0;
      end
      else if (ck_edge & rd_act)
        rd_wait <= rd_wait - 3'h1;
      else if (ck_edge | ~cke_s)
      begin
        DQ_OE  <= 1'b0;
        DQS_OE <= 1'b0;
      end
      if (wr_take)
      begin
        wr_beat <= wr_beat + 4'h1;
        if (wr_beat == beats - 4'h1)
          wr_act <= 1'b0;
      end
      else if (ck_edge & wr_act)
        wr_wait <= wr_wait - 3'h1;
      if (cmd_rd & bank_hit & ~cl_bad & (beats != 4'h0))
      begin
        rd_act   <= 1'b1;
        rd_wait  <= cl_half;
        rd_beat  <= 4'h0;
        rd_bank  <= ba_s;
        rd_start <= a_s[COLW-1:0];
        wr_act   <= 1'b0;
      end
      else if (cmd_bst)
        rd_act <= 1'b0;
      if (cmd_wr & bank_hit & (beats != 4'h0))
      begin
        wr_act   <= 1'b1;
        wr_wait  <= `DSCI_WR_HALF;
        wr_beat  <= 4'h0;
        wr_bank  <= ba_s;
        wr_start <= a_s[COLW-1:0];
        rd_act   <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Wishbone register file
  // ------------------------------------------------------------
  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
      ctrl_en  <= `DSCI_CTRL_RST;
    end
    else
    begin
      WB_ACK_O <= wb_req;
      if (wb_write && WB_ADR_I == `DSCI_ADR_CTRL)
        ctrl_en <= WB_DAT_I[`DSCI_CTRL_EN];
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req & ~WB_WE_I)
      begin
        case (WB_ADR_I)
          `DSCI_ADR_CTRL:   WB_DAT_O <= {31'h0, ctrl_en};
          `DSCI_ADR_STATUS: WB_DAT_O <= {15'h0, init_st, wr_act, rd_act, in_sr,
                                         dll_on & (dll_cnt == 8'h00), banks_open};
          `DSCI_ADR_MODE:   WB_DAT_O <= {20'h0, mode_reg};
          `DSCI_ADR_EXT:    WB_DAT_O <= {18'h0, ext_reg};
          `DSCI_ADR_ERR:    WB_DAT_O <= {25'h0, err};
          default:          WB_DAT_O <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule // dsci_core

/* File: tb/dsci_core_chk.sv */
`timescale 1ns/1ps

module dsci_core_chk (
  // System
  input wire        SYS_CLK,
  input wire        RST_N,
  // Register bus
  input wire        WB_CYC_I,
  input wire        WB_STB_I,
  input wire [31:0] WB_DAT_O,
  input wire        WB_ACK_O,
  // Memory pins
  input wire        CKE,
  input wire        CS_N,
  input wire        RAS_N,
  input wire        CAS_N,
  input wire        WE_N,
  input wire        DQ_OE,
  input wire        DQS_OE
);
  // ----
  // Cycles since read pins were last seen.
  // ----
  wire      rd_pins = !CS_N && RAS_N && !CAS_N && WE_N;
  reg [6:0] rd_age;

  always @(posedge SYS_CLK)
  begin
    if (!RST_N)
      rd_age <= 7'h7f;
    else if (rd_pins)
      rd_age <= 7'h0;
    else if (rd_age != 7'h7f)
      rd_age <= rd_age + 7'h1;
  end

  default clocking dc @(posedge SYS_CLK); endclocking
  default disable iff (!RST_N);

  sequence wb_req;
    WB_CYC_I && WB_STB_I && !WB_ACK_O;
  endsequence
  sequence ack_once;
    WB_ACK_O ##1 !WB_ACK_O;
  endsequence

  ack_follows_a: assert property (wb_req |=> ack_once)
    else $error("ack did not follow request");
  ack_drop_a: assert property (WB_ACK_O && WB_STB_I |=> !WB_ACK_O)
    else $error("ack held while strobe stays");
  ack_cause_a: assert property ($rose(WB_ACK_O) |-> $past(WB_STB_I) && $past(WB_CYC_I))
    else $error("ack without request");
  dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == 32'h0)
    else $error("read data outside ack");
  strobe_oe_a: assert property (DQS_OE == DQ_OE)
    else $error("strobe enable differs from data enable");
  cke_quiet_a: assert property (!CKE [*8] |-> !DQ_OE)
    else $error("data driven with clock enable low");
  read_recent_a: assert property (DQ_OE |-> rd_age <= 7'd80)
    else $error("data driven without recent read");
  read_late_a: assert property ($rose(DQ_OE) |-> rd_age >= 7'd8)
    else $error("read data earlier than latency");
endmodule // dsci_core_chk

bind dsci_core dsci_core_chk i_chk (
  .SYS_CLK(SYS_CLK), .RST_N(RST_N), .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I),
  .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N),
  .CAS_N(CAS_N), .WE_N(WE_N), .DQ_OE(DQ_OE), .DQS_OE(DQS_OE));

/* File: tb/dsci_ctrl_model.sv */
`timescale 1ns/1ps

module dsci_ctrl_model #(
  parameter pwr_ck = 8
) (
  // System
  input  wire        sys_clk,
  // Command pins
  output reg         ck,
  output reg         cke,
  output reg  [3:0]  cmd,
  output reg  [1:0]  ba,
  output reg  [11:0] a,
  // Data pins
  output reg  [3:0]  dm,
  output reg  [31:0] dq
);
  // Clock enable stays low and the device is deselected at power-up.
  initial
  begin
    cke = 1'b0;
    cmd = 4'hf;
    ba = 2'h0;
    a = 12'h0;
    dm = 4'h0;
    dq = 32'h5a5a_c3c3;
    ck = 1'b0;
    #37;
    forever #100 ck = ~ck;
  end

  // Pins change after a falling edge and hold across the next rise.
  task issue(input [3:0] c, input [1:0] b, input [11:0] ad);
    @(negedge ck);
    @(posedge sys_clk);
    cmd <= c;
    ba <= b;
    a <= ad;
  endtask

  task nop(input integer n);
    repeat (n) issue(4'h7, 2'h0, 12'h0);
  endtask

  // The wait stands in for the long settle time.
  task power_up;
    repeat (pwr_ck) @(posedge ck);
    issue(4'h7, 2'h0, 12'h0);
    cke <= 1'b1;
  endtask

  // Beats change two system clocks after each clock edge; the bus is inverted after.
  task write4(input [1:0] b, input [7:0] col, input [127:0] d);
    integer k;
    issue(4'h4, b, {4'h0, col});
    nop(1);
    @(posedge sys_clk);
    dq <= d[31:0];
    for (k = 1; k < 5; k = k + 1)
    begin
      @(ck);
      repeat (2) @(posedge sys_clk);
      dq <= (k == 4) ? ~dq : d[32*k +: 32];
    end
  endtask
endmodule // dsci_ctrl_model

/* File: tb/ddr_sdram_command_init_mode_tb_top.sv */
`timescale 1ns/1ps
`include "dsci_map.vh"

module ddr_sdram_command_init_mode_tb_top;
  // Bench signals
  reg          sys_clk;
  reg          rst_n;
  reg          req;
  reg          we;
  reg  [7:0]   adr;
  reg  [31:0]  wdat;
  reg  [31:0]  rv;
  wire [31:0]  rdat;
  wire         ack;
  wire         ck;
  wire         cke;
  wire [3:0]   cmd;
  wire [1:0]   ba;
  wire [11:0]  a;
  wire [3:0]   dm;
  wire [31:0]  dq_in;
  wire [31:0]  dq_out;
  wire         dq_oe;
  wire         dqs_out;
  wire         dqs_oe;
  integer      error_cnt;
  integer      samples_checked;
  integer      cycles;
  localparam [3:0]  c_act = 4'h3, c_rd = 4'h5, c_pre = 4'h2, c_ref = 4'h1, c_mrs = 4'h0;
  localparam [31:0] d0 = 32'h1111_0001, d1 = 32'h2222_0002;
  localparam [31:0] d2 = 32'h3333_0003, d3 = 32'h4444_0004;

  initial
  begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    req = 1'b0;
    we = 1'b0;
    adr = 8'h0;
    wdat = 32'h0;
    error_cnt = 0;
    samples_checked = 0;
    cycles = 0;
  end

  always #12.5 sys_clk = ~sys_clk;

  dsci_core i_dut (
    .SYS_CLK(sys_clk), .RST_N(rst_n), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(4'hf), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack),
    .CK(ck), .CKE(cke), .CS_N(cmd[3]), .RAS_N(cmd[2]), .CAS_N(cmd[1]), .WE_N(cmd[0]),
    .BA(ba), .A(a), .DM(dm), .DQ_IN(dq_in), .DQ_OUT(dq_out), .DQ_OE(dq_oe),
    .DQS_OUT(dqs_out), .DQS_OE(dqs_oe));

  dsci_ctrl_model i_mdl (
    .sys_clk(sys_clk), .ck(ck), .cke(cke), .cmd(cmd), .ba(ba), .a(a), .dm(dm),
    .dq(dq_in));

  // ----
  // Shared tasks
  // ----
  task chk(input string nm, input [31:0] exp, input [31:0] got);
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      error_cnt = error_cnt + 1;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task wb(input w, input [7:0] ad, input [31:0] d);
    integer n;
    n = 0;
    @(posedge sys_clk);
    req <= 1'b1;
    we <= w;
    adr <= ad;
    wdat <= d;
    do
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
    while (ack !== 1'b1 && n < 40);
    rv = rdat;
    req <= 1'b0;
    if (n >= 40)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  endtask

  task rchk(input string nm, input [7:0] ad, input [31:0] exp);
    wb(1'b0, ad, 32'h0);
    chk(nm, exp, rv);
  endtask

  task step(input [3:0] c, input [1:0] b, input [11:0] ad);
    i_mdl.issue(c, b, ad);
    i_mdl.nop(2);
  endtask

  task rbank(input [3:0] exp);
    wb(1'b0, `DSCI_ADR_STATUS, 32'h0);
    chk("open banks", {28'h0, exp}, {28'h0, rv[3:0]});
  endtask

  task rd_burst(input [7:0] col, input integer bl, input [127:0] exp);
    integer k;
    integer n;
    i_mdl.issue(c_rd, 2'h0, {4'h0, col});
    i_mdl.nop(1);
    n = 0;
    while (dq_oe !== 1'b1 && n < 80)
    begin
      @(posedge sys_clk);
      n = n + 1;
    end
    repeat (2) @(posedge sys_clk);
    for (k = 0; k < bl; k = k + 1)
    begin
      chk("read beat", exp[32*k +: 32], dq_out);
      chk("strobe", {31'h0, ~k[0]}, {31'h0, dqs_out});
      repeat (4) @(posedge sys_clk);
    end
    repeat (4) @(posedge sys_clk);
    chk("dq enable", 32'h0, {31'h0, dq_oe});
  endtask

  // ----
  // Scenarios
  // ----
  task t_reset;
    rchk("status", `DSCI_ADR_STATUS, 32'h0000_0100);
    rchk("mode", `DSCI_ADR_MODE, 32'h0);
    rchk("unmapped", 8'h40, 32'h0);
    chk("dq enable", 32'h0, {31'h0, dq_oe});
  endtask

  task t_init;
    i_mdl.power_up;
    step(c_pre, 2'h0, 12'h100);
    step(c_mrs, 2'h1, 12'h000);
    step(c_mrs, 2'h0, 12'h122);
    rchk("status", `DSCI_ADR_STATUS, 32'h0000_1000);
    i_mdl.nop(200);
    step(c_pre, 2'h0, 12'h100);
    step(c_ref, 2'h0, 12'h0);
    step(c_ref, 2'h0, 12'h0);
    step(c_mrs, 2'h0, 12'h022);
    rchk("status", `DSCI_ADR_STATUS, 32'h0001_0010);
    rchk("mode", `DSCI_ADR_MODE, 32'h0000_0022);
    rchk("ext", `DSCI_ADR_EXT, 32'h0000_1000);
    rchk("errors", `DSCI_ADR_ERR, 32'h0);
  endtask

  task t_banks;
    step(c_act, 2'h2, 12'h0);
    rbank(4'b0100);
    step(c_act, 2'h3, 12'h0);
    rbank(4'b1100);
    step(c_pre, 2'h2, 12'h0);
    rbank(4'b1000);
    step(4'hb, 2'h0, 12'h0);
    rbank(4'b1000);
    wb(1'b1, `DSCI_ADR_CTRL, 32'h0);
    step(c_act, 2'h1, 12'h0);
    rbank(4'b1000);
    wb(1'b1, `DSCI_ADR_CTRL, 32'h1);
    step(c_pre, 2'h1, 12'h100);
    rbank(4'b0000);
    step(c_rd, 2'h0, 12'h0);
    rchk("errors", `DSCI_ADR_ERR, 32'h10);
    wb(1'b1, `DSCI_ADR_ERR, 32'hff);
    rchk("errors", `DSCI_ADR_ERR, 32'h0);
  endtask

  task t_burst;
    step(c_act, 2'h0, 12'h0);
    i_mdl.write4(2'h0, 8'h00, {d3, d2, d1, d0});
    i_mdl.nop(2);
    rd_burst(8'h01, 4, {d0, d3, d2, d1});
    step(c_pre, 2'h0, 12'h100);
    step(c_mrs, 2'h0, 12'h02a);
    step(c_act, 2'h0, 12'h0);
    rd_burst(8'h01, 4, {d2, d3, d0, d1});
    step(c_pre, 2'h0, 12'h100);
    step(c_mrs, 2'h0, 12'h021);
    step(c_act, 2'h0, 12'h0);
    rd_burst(8'h03, 2, {64'h0, d2, d3});
  endtask

  // Every error flag except the closed-bank one is raised by a deliberately broken command stream.
  task t_errs;
    wb(1'b1, `DSCI_ADR_ERR, 32'h7f);
    i_mdl.issue(c_mrs, 2'h0, 12'h022);
    step(c_act, 2'h0, 12'h0);
    rchk("errors", `DSCI_ADR_ERR, 32'h43);
    wb(1'b1, `DSCI_ADR_ERR, 32'h7f);
    step(c_pre, 2'h0, 12'h100);
    step(c_mrs, 2'h1, 12'h000);
    step(c_act, 2'h0, 12'h0);
    step(c_rd, 2'h0, 12'h0);
    rchk("errors", `DSCI_ADR_ERR, 32'h08);
    wb(1'b1, `DSCI_ADR_ERR, 32'h7f);
    step(c_pre, 2'h0, 12'h100);
    step(c_mrs, 2'h0, 12'h002);
    step(c_act, 2'h0, 12'h0);
    step(c_rd, 2'h0, 12'h0);
    rchk("errors", `DSCI_ADR_ERR, 32'h28);
    wb(1'b1, `DSCI_ADR_ERR, 32'h7f);
    step(c_pre, 2'h0, 12'h100);
    step(c_mrs, 2'h0, 12'h122);
    step(c_act, 2'h0, 12'h0);
    rchk("errors", `DSCI_ADR_ERR, 32'h04);
  endtask

  task wrap_up;
    if (error_cnt == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  always @(posedge sys_clk)
  begin
    cycles = cycles + 1;
    if (cycles > 12000)
    begin
      error_cnt = error_cnt + 1;
      wrap_up;
    end
  end

  initial
  begin
    repeat (10) @(posedge sys_clk);
    rst_n <= 1'b1;
    t_reset;
    t_init;
    t_banks;
    t_burst;
    t_errs;
    wrap_up;
  end
endmodule // ddr_sdram_command_init_mode_tb_top
